// ===== rtl/clsd_pkg.sv
// Shared constants and types of the clock-loss monitor with output shut-off.
// Assumes a single pclk domain; both monitored clocks arrive as sampled inputs.
package clsd_pkg;

  // Register map, byte addresses on APB
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  REG_GENERAL_OFF = 8'h00;
  localparam logic [7:0]  REG_SHUTOFF_OFF = 8'h08;
  localparam logic [7:0]  REG_STATUS_OFF  = 8'h14;
  localparam logic [7:0]  REG_MASK_OFF    = 8'h1C;

  // Field layout
  localparam int          ALARM_W         = 3;
  localparam int          ALM_SAMPLE      = 0;
  localparam int          ALM_INPUT       = 1;
  localparam int          ALM_COLL        = 2;
  localparam int          LIVE_LSB        = 8;
  localparam int          GEN_INTERP_LSB  = 0;
  localparam int          GEN_INTERP_W    = 3;
  localparam int          GEN_POL_BIT     = 3;

  // Reset values
  localparam logic [31:0] GEN_RESET       = 32'h0000_0008;
  localparam logic [31:0] SHUT_RESET      = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0007;

  // Loss thresholds in periods of the surviving clock
  localparam int          IN_LOSS_LANE    = 13;
  localparam int          IN_LOSS_ILV     = 23;
  localparam int          SMP_LOSS_LANE   = 14;
  localparam int          SMP_LOSS_ILV    = 24;
  localparam int          SHUTOFF_PIPE    = 12;
  localparam int          INTERP_MAX_LOG  = 4;

  // Data path
  localparam int          WORD_W          = 16;
  localparam int          ILV_WORDS       = 4;
  localparam logic [15:0] MID_CODE        = 16'h8000;

  typedef struct packed {
    logic collision;
    logic input_lost;
    logic sample_lost;
  } clsd_alarm_t;

endpackage : clsd_pkg

// ===== rtl/clsd_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; write and read may happen in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module clsd_fifo
  import clsd_pkg::*;
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_param
    $error("clsd_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire              empty = (wr_ptr_r == rd_ptr_r);
  wire              do_wr = in_valid && !full;
  wire              do_rd = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  // Storage has no reset; contents are only read behind valid
  always_ff @(posedge pclk)
  begin
    if (do_wr)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_rd)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule // clsd_fifo

`default_nettype wire

// ===== rtl/clsd_loss_det.sv
// Clock-loss detector: counts ticks of the surviving clock since the
// monitored clock was last seen active.
// Assumes both ticks are one-cycle pulses already synchronised to pclk.
`timescale 1ns/10ps
`default_nettype none
module clsd_loss_det
  import clsd_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Activity
  input  wire logic             ref_tick,
  input  wire logic             mon_tick,
  input  wire logic [CNT_W-1:0] limit,
  // Result
  output logic                  lost
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Saturates at the limit so a long outage never wraps back to clear
  assign lost    = (cnt_r >= limit);
  assign cnt_nxt = mon_tick ? '0 : ((ref_tick && !lost) ? cnt_r + 1'b1 : cnt_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule // clsd_loss_det

`default_nettype wire

// ===== rtl/clsd_top.sv
// Clock-loss fault monitor with automatic converter output shut-off.
// Assumes input latch clock and sample clock are slow against pclk and
// arrive as plain inputs; APB master follows the usual setup/access rule.
//
// Notes on behaviour
// - Lane variant: input loss alarms after 13 periods
// - Forced value applied 12 sample periods after detection
// - Shut-off drives mid-scale code on output
// - Shut-off may precede the fault pin
// - Sample clock stopped: output holds last value
// - Lane variant: sample loss alarms after 14
// - Interleaved variant: sample loss alarms after 24
// - Interleaved variant: input loss alarms after 23
// - Interleaved: four 16-bit words over two cycles
// - Interleaved 1x: shut-off about 59 ns later
// - Input clock is sample rate over interpolation
// - Oscillator enable adds no alarm latency
// - Enabled input-loss and collision alarms force output off despite gate
// - Alarm flags sticky; cleared by writing zero
// - Only unmasked alarms drive the fault pin
// - Fault pin polarity set by configuration bit
`timescale 1ns/10ps
`default_nettype none
module clsd_top
  import clsd_pkg::*;
#(
  parameter int CHANNELS    = 4,
  parameter bit INTERLEAVED = 1'b0,
  parameter int FIFO_DEPTH  = 32,
  parameter int CNT_W       = 10
)
(
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Data source side
  input  wire logic                         in_clk,
  input  wire logic [WORD_W*CHANNELS-1:0]   in_data,
  output logic                              in_ready,
  input  wire logic                         tx_enable,
  // Converter side
  input  wire logic                         smp_clk,
  output logic      [WORD_W*CHANNELS-1:0]   dac_out,
  output logic                              shutoff_active,
  // Fault pin
  output logic                              fault_out
);

  localparam int DATA_W = WORD_W * CHANNELS;

  if (CHANNELS < 1 || (INTERLEAVED && CHANNELS != ILV_WORDS) || CNT_W < 10)
  begin : g_bad_param
    $error("clsd_top: interleaved needs four channels; CNT_W must hold 24 << 4");
  end

  // Registers
  logic [31:0]        general_setup_reg_r;
  logic [31:0]        shutoff_enable_reg_r;
  logic [31:0]        alarm_mask_reg_r;
  clsd_alarm_t        alarm_status_reg_r;
  clsd_alarm_t        alarm_status_reg_nxt;
  clsd_alarm_t        alarm_set;
  clsd_alarm_t        alarm_live;
  logic [31:0]        prdata_r;
  logic               pslverr_r;
  logic               fault_out_r;

  // APB decode
  wire                setup_ph  = psel && !penable;
  wire                write_acc = psel && penable && pwrite;
  wire                hit_gen   = (paddr == REG_GENERAL_OFF);
  wire                hit_shut  = (paddr == REG_SHUTOFF_OFF);
  wire                hit_stat  = (paddr == REG_STATUS_OFF);
  wire                hit_mask  = (paddr == REG_MASK_OFF);
  wire                hit_any   = hit_gen || hit_shut || hit_stat || hit_mask;
  wire [31:0]         stat_word = {{(32-LIVE_LSB-ALARM_W){1'b0}}, alarm_live,
                                   {(LIVE_LSB-ALARM_W){1'b0}}, alarm_status_reg_r};
  wire [31:0]         rd_mux    = hit_gen  ? general_setup_reg_r  :
                                  hit_shut ? shutoff_enable_reg_r :
                                  hit_stat ? stat_word            :
                                  hit_mask ? alarm_mask_reg_r     : 32'h0000_0000;

  // Read data latched in setup so it comes from a flop; no wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // Write zero clears a flag; a new event in the same cycle still sets it
  wire [ALARM_W-1:0]  clr_keep  = (write_acc && hit_stat) ? pwdata[ALARM_W-1:0] : {ALARM_W{1'b1}};
  assign alarm_status_reg_nxt = (alarm_status_reg_r & clr_keep) | alarm_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      general_setup_reg_r  <= GEN_RESET;
      shutoff_enable_reg_r <= SHUT_RESET;
      alarm_mask_reg_r     <= MASK_RESET;
      alarm_status_reg_r   <= '0;
      prdata_r             <= 32'h0000_0000;
      pslverr_r            <= 1'b0;
    end
    else
    begin
      alarm_status_reg_r <= alarm_status_reg_nxt;
      if (setup_ph)
      begin
        prdata_r  <= rd_mux;
        pslverr_r <= !hit_any;
      end
      if (write_acc && hit_gen)
        general_setup_reg_r <= pwdata;
      if (write_acc && hit_shut)
        shutoff_enable_reg_r <= pwdata;
      if (write_acc && hit_mask)
        alarm_mask_reg_r <= pwdata;
    end
  end

  // Clock samplers
  // Third stage only feeds edge detection; first stage is read by the second alone
  logic [2:0]         in_sync_r;
  logic [2:0]         smp_sync_r;
  wire                in_rise   = in_sync_r[1] && !in_sync_r[2];
  wire                in_edge   = in_sync_r[1] ^ in_sync_r[2];
  wire                smp_rise  = smp_sync_r[1] && !smp_sync_r[2];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_sync_r  <= 3'h0;
      smp_sync_r <= 3'h0;
    end
    else
    begin
      in_sync_r  <= {in_sync_r[1:0], in_clk};
      smp_sync_r <= {smp_sync_r[1:0], smp_clk};
    end
  end

  // Interpolation setting
  // Input clock runs at sample rate over 2**interp_log; larger codes clamp
  wire [GEN_INTERP_W-1:0] interp_raw = general_setup_reg_r[GEN_INTERP_LSB +: GEN_INTERP_W];
  wire [GEN_INTERP_W-1:0] interp_log = (interp_raw > GEN_INTERP_W'(INTERP_MAX_LOG)) ?
                                       GEN_INTERP_W'(INTERP_MAX_LOG) : interp_raw;

  // Loss detectors
  // Input loss counted in sample periods: threshold scales with interpolation,
  // so the alarm stays at a fixed number of input periods
  wire [CNT_W-1:0]    in_base   = INTERLEAVED ? CNT_W'(IN_LOSS_ILV) : CNT_W'(IN_LOSS_LANE);
  wire [CNT_W-1:0]    in_limit  = in_base << interp_log;
  wire [CNT_W-1:0]    smp_limit = INTERLEAVED ? CNT_W'(SMP_LOSS_ILV) : CNT_W'(SMP_LOSS_LANE);
  logic               in_lost;
  logic               smp_lost;

  clsd_loss_det #(.CNT_W(CNT_W)) u_in_loss
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .ref_tick (smp_rise),
    .mon_tick (in_rise),
    .limit    (in_limit),
    .lost     (in_lost)
  );

  // Sample loss judged by the input clock, which survives it
  clsd_loss_det #(.CNT_W(CNT_W)) u_smp_loss
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .ref_tick (in_rise),
    .mon_tick (smp_rise),
    .limit    (smp_limit),
    .lost     (smp_lost)
  );

  // Input capture
  logic [DATA_W-1:0]  asm_r;
  logic [1:0]         word_cnt_r;
  logic               push;
  logic [DATA_W-1:0]  push_data;
  logic               fifo_out_valid;
  logic [DATA_W-1:0]  fifo_out_data;
  logic               pop;

  if (INTERLEAVED)
  begin : g_ilv
    // One 16-bit word per input edge, four words make one sample set
    wire last_word = (word_cnt_r == 2'(ILV_WORDS - 1));
    assign push      = in_edge && last_word;
    assign push_data = {in_data[WORD_W-1:0], asm_r[DATA_W-WORD_W-1:0]};
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        asm_r      <= '0;
        word_cnt_r <= 2'h0;
      end
      else if (in_lost)
        word_cnt_r <= 2'h0;
      else if (in_edge && (word_cnt_r != 2'h0 || in_rise))
      begin
        asm_r[word_cnt_r*WORD_W +: WORD_W] <= in_data[WORD_W-1:0];
        word_cnt_r                         <= word_cnt_r + 2'h1;
      end
    end
  end
  else
  begin : g_lane
    assign push      = in_rise;
    assign push_data = in_data;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        asm_r      <= '0;
        word_cnt_r <= 2'h0;
      end
      else
      begin
        asm_r      <= asm_r;
        word_cnt_r <= 2'h0;
      end
    end
  end

  clsd_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_data   (push_data),
    .in_ready  (in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (pop)
  );

  // Output decoder
  // Everything below advances only on sample clock edges, so a stopped
  // sample clock freezes the output on its last code
  logic [INTERP_MAX_LOG:0]  phase_r;
  logic [SHUTOFF_PIPE-1:0]  force_pipe_r;
  logic [DATA_W-1:0]        dac_out_r;
  wire [INTERP_MAX_LOG:0]   phase_last = (INTERP_MAX_LOG+1)'((1 << interp_log) - 1);
  wire                      want       = smp_rise && (phase_r == '0);
  assign pop = want && fifo_out_valid;

  // Shut-off request is taken from the input-loss detector, the sticky collision flag and tx_enable low, not the fault pin
  wire                      force_req  = (in_lost   && shutoff_enable_reg_r[ALM_INPUT]) ||
                                         (alarm_status_reg_r.collision && shutoff_enable_reg_r[ALM_COLL]) ||
                                         !tx_enable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_r      <= '0;
      force_pipe_r <= '0;
      dac_out_r    <= {CHANNELS{MID_CODE}};
    end
    else if (smp_rise)
    begin
      phase_r      <= (phase_r >= phase_last) ? '0 : phase_r + 1'b1;
      force_pipe_r <= {force_pipe_r[SHUTOFF_PIPE-2:0], force_req};
      if (force_pipe_r[SHUTOFF_PIPE-1])
        dac_out_r <= {CHANNELS{MID_CODE}};
      else if (pop)
        dac_out_r <= fifo_out_data;
    end
  end

  assign dac_out        = dac_out_r;
  assign shutoff_active = force_pipe_r[SHUTOFF_PIPE-1];

  // Alarm logic
  // Overflow, and underrun while the input clock is not lost, count as a pointer collision
  assign alarm_live.sample_lost = smp_lost;
  assign alarm_live.input_lost  = in_lost;
  assign alarm_live.collision   = (push && !in_ready) || (want && !fifo_out_valid && !in_lost);
  assign alarm_set              = alarm_live;

  wire                fault_any = |(alarm_status_reg_r & ~alarm_mask_reg_r[ALARM_W-1:0]);
  wire                fault_nxt = general_setup_reg_r[GEN_POL_BIT] ? fault_any : !fault_any;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_out_r <= 1'b0;
    else
      fault_out_r <= fault_nxt;
  end

  assign fault_out = fault_out_r;

endmodule // clsd_top

`default_nettype wire

// ===== tb/clsd_top_assertions.sv
// Port-level assertions for the clock-loss monitor top module.
// Assumes it is bound into clsd_top; everything runs on pclk.
`timescale 1ns/10ps
`default_nettype none
module clsd_top_assertions
  import clsd_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // APB
  input wire logic [ADDR_W-1:0]          paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Data and converter
  input wire logic                       in_clk,
  input wire logic [WORD_W*CHANNELS-1:0] in_data,
  input wire logic                       in_ready,
  input wire logic                       tx_enable,
  input wire logic                       smp_clk,
  input wire logic [WORD_W*CHANNELS-1:0] dac_out,
  input wire logic                       shutoff_active,
  input wire logic                       fault_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       mapped;
  logic       smp_d_r;
  logic [3:0] quiet_r;
  assign mapped = paddr inside {REG_GENERAL_OFF, REG_SHUTOFF_OFF, REG_STATUS_OFF, REG_MASK_OFF};
  // Idle time of the sample clock; margin covers the sync delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smp_d_r <= 1'b0;
      quiet_r <= 4'h0;
    end
    else
    begin
      smp_d_r <= smp_clk;
      quiet_r <= (smp_clk != smp_d_r) ? 4'h0 : (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence forced_s;
    shutoff_active [*8] ##1 shutoff_active [*8];
  endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (setup_s ##0 !mapped |=> pslverr) else $error("no error on bad address");
  mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr) else $error("error on good address");
  unmapped_zero_a: assert property (setup_s ##0 !mapped |=> prdata == 32'h0000_0000) else $error("bad read data");
  read_stands_a: assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved in access");
  out_freeze_a: assert property (quiet_r >= 4'h8 |-> $stable(dac_out)) else $error("output moved");
  mid_reach_a: assert property ($rose(shutoff_active) |-> ##[0:12] dac_out == {CHANNELS{MID_CODE}})
    else $error("no mid code after shut-off");
  mid_hold_a: assert property (forced_s |-> dac_out == {CHANNELS{MID_CODE}})
    else $error("shut-off not holding mid code");
endmodule // clsd_top_assertions

bind clsd_top clsd_top_assertions #(.CHANNELS(CHANNELS)) u_chk
(
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_clk(in_clk),
  .in_data(in_data), .in_ready(in_ready), .tx_enable(tx_enable), .smp_clk(smp_clk),
  .dac_out(dac_out), .shutoff_active(shutoff_active), .fault_out(fault_out)
);
`default_nettype wire

// ===== tb/clsd_source_model.sv
// Data source model: input latch clock and one 4-word set per rise.
// Assumes lane mode at 1x; holds off while the monitor is not ready.
`timescale 1ns/10ps
`default_nettype none
module clsd_source_model
  import clsd_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control and link
  input  wire logic        run,
  input  wire logic        in_ready,
  output logic             in_clk,
  output logic      [63:0] in_data
);
  logic [1:0]  ph_r;
  logic [15:0] cnt_r;
  logic        stale_r;
  function automatic logic [63:0] set_of(input logic [15:0] c);
    return {c + 16'h0003, c + 16'h0002, c + 16'h0001, c};
  endfunction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_r <= 2'h0;
      in_clk <= 1'b0;
      cnt_r <= 16'h0000;
      stale_r <= 1'b1;
      in_data <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3 && in_clk)
      begin
        in_clk <= 1'b0;
        cnt_r <= cnt_r + 16'h0001;
        in_data <= set_of(cnt_r + 16'h0001);
      end
      // Stalled bus inverts every cycle, so it carries the last set on alternate cycles
      else if (!in_clk && !(run && in_ready))
      begin
        in_data <= ~in_data;
        stale_r <= 1'b1;
      end
      else if (ph_r == 2'h3 && stale_r)
      begin
        in_data <= set_of(cnt_r);
        stale_r <= 1'b0;
      end
      else if (ph_r == 2'h3)
        in_clk <= 1'b1;
    end
  end
endmodule // clsd_source_model
`default_nettype wire

// ===== tb/clock_loss_output_shutoff_test.sv
// Bench of the clock-loss monitor: APB tasks, source model, sample clock.
// Assumes lane mode at 1x, both monitored clocks at pclk/8.
`timescale 1ns/10ps
`default_nettype none
module clock_loss_output_shutoff_test
  import clsd_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        tx_enable = 1'b1;
  logic        smp_clk = 1'b0;
  logic        run_in = 1'b0;
  logic        run_smp = 1'b0;
  logic [1:0]  sp = 2'h1;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, in_clk, in_ready, shutoff_active, fault_out;
  logic [63:0] in_data, dac_out, held;
  logic [7:0]  ra [4] = '{REG_GENERAL_OFF, REG_SHUTOFF_OFF, REG_MASK_OFF, 8'h04};
  logic [31:0] rv [4] = '{GEN_RESET, SHUT_RESET, MASK_RESET, 32'h0};
  int          error_cnt = 0, num_checks = 0, cyc = 0, smp_rises = 0, in_rises = 0, n;

  clsd_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_clk(in_clk), .in_data(in_data), .in_ready(in_ready), .tx_enable(tx_enable), .smp_clk(smp_clk),
    .dac_out(dac_out), .shutoff_active(shutoff_active), .fault_out(fault_out));
  clsd_source_model src (.pclk(pclk), .presetn(presetn), .run(run_in), .in_ready(in_ready),
    .in_clk(in_clk), .in_data(in_data));

  always #5 pclk = ~pclk;
  // Sample clock stands low when stopped, never mid-pulse
  always @(posedge pclk)
  begin
    sp <= sp + 2'h1;
    if (sp == 2'h3 && (run_smp || smp_clk))
    begin
      smp_clk <= ~smp_clk;
      smp_rises <= smp_rises + (smp_clk ? 0 : 1);
    end
  end
  always @(posedge in_clk) in_rises++;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task end_sim;
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_hi(input bit sel);
    int k;
    k = 0;
    while ((sel ? shutoff_active : fault_out) !== 1'b1 && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
    chk(k < 3000, 1);
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    run_in <= 1'b1;
    repeat (20) @(posedge pclk);
    run_smp <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rdat, rv[i]);
      chk(rerr, i == 3);
    end
    repeat (100) @(posedge pclk);
    chk(dac_out[31:16], dac_out[15:0] + 16'h0001);
    // Gate low forces mid through the pipe, then drains before the loss tests
    tx_enable <= 1'b0;
    wait_hi(1'b1);
    repeat (20) @(posedge pclk);
    chk(dac_out, {4{MID_CODE}});
    tx_enable <= 1'b1;
    repeat (150) @(posedge pclk);
    chk(shutoff_active, 1'b0);
    // Collision masked so that only clock loss reaches the pin
    apb(1'b1, REG_MASK_OFF, 32'h4);
    apb(1'b1, REG_SHUTOFF_OFF, 32'h2);
    apb(1'b1, REG_STATUS_OFF, 32'h0);
    apb(1'b0, REG_STATUS_OFF, 32'h0);
    chk(rdat[2:0], 3'h0);
    run_in <= 1'b0;
    n = smp_rises;
    wait_hi(1'b0);
    chk((smp_rises - n) inside {[12:16]}, 1);
    n = smp_rises;
    wait_hi(1'b1);
    chk((smp_rises - n) inside {[10:13]}, 1);
    repeat (20) @(posedge pclk);
    chk(dac_out, {4{MID_CODE}});
    run_in <= 1'b1;
    repeat (100) @(posedge pclk);
    apb(1'b0, REG_STATUS_OFF, 32'h0);
    chk(rdat[1], 1'b1);
    apb(1'b1, REG_STATUS_OFF, 32'h0);
    apb(1'b0, REG_STATUS_OFF, 32'h0);
    chk(rdat[1], 1'b0);
    chk(fault_out, 1'b0);
    run_smp <= 1'b0;
    n = in_rises;
    repeat (10) @(posedge pclk);
    held = dac_out;
    wait_hi(1'b0);
    chk((in_rises - n) inside {[13:17]}, 1);
    chk(dac_out, held);
    apb(1'b1, REG_GENERAL_OFF, 32'h0);
    repeat (3) @(posedge pclk);
    chk(fault_out, 1'b0);
    apb(1'b1, REG_GENERAL_OFF, GEN_RESET);
    apb(1'b1, REG_MASK_OFF, 32'h7);
    repeat (3) @(posedge pclk);
    chk(fault_out, 1'b0);
    apb(1'b0, REG_STATUS_OFF, 32'h0);
    chk(rdat[0], 1'b1);
    repeat (400) @(posedge pclk);
    chk(in_ready, 1'b0);
    run_smp <= 1'b1;
    n = 0;
    while (in_ready !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk(in_ready, 1'b1);
    end_sim();
  end
endmodule // clock_loss_output_shutoff_test
`default_nettype wire
